/* File: atf_top.sv */
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
module atf_top (
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and converter core
  input wire logic ext_trigger_in,
  input wire logic aux_clk_in,
  input wire logic pen_detect_in,
  input wire logic [12:0] conv_data_in,
  output logic conv_start,
  output logic conv_clk_en,
  output atf_pkg::atf_route_t route,
  output logic conv_irq_line,
  output logic conv_wake_line
);
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [2:0] ctl_q;
  logic [15:0] dly_q;
  logic [7:0] aux_q;
  atf_pkg::atf_route_t gcr_q;
  logic [7:0] div_cnt_q;
  logic [7:0] cdel_q;
  logic aux_s1_q, aux_s2_q, aux_s3_q;
  logic tick_q;
  logic trg_s1_q, trg_s2_q, trg_f_q;
  logic [3:0] glitch_q;
  logic pen_s1_q, pen_s2_q;
  logic armed_q, sw_pend_q;
  atf_pkg::atf_seq_t seq_q;
  logic [7:0] dly_cnt_q;
  logic [1:0] dly_div_q;
  logic [7:0] conv_cnt_q;
  logic push_q;
  atf_pkg::atf_entry_t fifo_q [atf_pkg::FIFO_DEPTH];
  logic [1:0] wp_q, rp_q;
  logic [2:0] cnt_q;
  logic ovf_q, done_q;
  logic pop_gap_q, wake_q, irq_q;
  logic wr_fire, rd_fire, sw_start, pop, edge_hit, cc_tick;
  logic [7:0] rd_addr;

  function automatic logic sel_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Write channel
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign sw_start = wr_fire && sel_hit(awaddr_q, atf_pkg::OFF_START);
  assign rd_addr = s_axi_araddr;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign pop = rd_fire && sel_hit(rd_addr, atf_pkg::OFF_RESULT) && cnt_q != 3'h0;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  assign s_axi_bresp = 2'h0;

  // Config registers; an all-zero strobe blocks the write, any other strobe writes the full word
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctl_q <= 3'h0;
      dly_q <= 16'h0;
      aux_q <= atf_pkg::RST_CLK_DIV;
      gcr_q <= '0;
    end
    else if (wr_fire && s_axi_wstrb != 4'h0)
    begin
      if (sel_hit(awaddr_q, atf_pkg::OFF_CONTROL))
        ctl_q <= wdata_q[2:0];
      if (sel_hit(awaddr_q, atf_pkg::OFF_DELAY))
        dly_q <= wdata_q[15:0];
      if (sel_hit(awaddr_q, atf_pkg::OFF_AUX))
        aux_q <= wdata_q[7:0];
      if (sel_hit(awaddr_q, atf_pkg::OFF_GLOBAL))
        gcr_q <= wdata_q[11:0];
    end

  // Read channel, one cycle answer
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        unique case (rd_addr)
          atf_pkg::OFF_CONTROL: s_axi_rdata <= {29'h0, ctl_q};
          atf_pkg::OFF_DELAY: s_axi_rdata <= {16'h0, dly_q};
          atf_pkg::OFF_AUX: s_axi_rdata <= {24'h0, aux_q};
          atf_pkg::OFF_GLOBAL: s_axi_rdata <= {20'h0, gcr_q};
          atf_pkg::OFF_RESULT: s_axi_rdata <= {15'h0, cnt_q != 3'h0, done_q,
            ovf_q | fifo_q[rp_q].ovf, gcr_q.touch == atf_pkg::TOUCH_PEN && pen_s2_q,
            fifo_q[rp_q].data};
          default: s_axi_rdata <= 32'h0;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  assign s_axi_rresp = 2'h0;

  // Converter clock: divider from clk or synchronised aux clock, then delay taps
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      div_cnt_q <= 8'h00;
      aux_s1_q <= 1'b0;
      aux_s2_q <= 1'b0;
      aux_s3_q <= 1'b0;
      cdel_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      aux_s1_q <= aux_clk_in;
      aux_s2_q <= aux_s1_q;
      aux_s3_q <= aux_s2_q;
      div_cnt_q <= (div_cnt_q >= aux_q[6:0]) ? 8'h00 : div_cnt_q + 8'h01;
      cdel_q <= {cdel_q[6:0], aux_q[7] ? (aux_s2_q && !aux_s3_q) : (div_cnt_q == 8'h00)};
      tick_q <= cdel_q[dly_q[10:8]];
    end
  assign cc_tick = tick_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      conv_clk_en <= 1'b0;
    else
      conv_clk_en <= cdel_q[dly_q[10:8]];

  // Trigger input: sync then glitch filter
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_f_q <= 1'b0;
      glitch_q <= 4'h0;
      pen_s1_q <= 1'b0;
      pen_s2_q <= 1'b0;
    end
    else
    begin
      trg_s1_q <= ext_trigger_in;
      trg_s2_q <= trg_s1_q;
      pen_s1_q <= pen_detect_in;
      pen_s2_q <= pen_s1_q;
      if (trg_s2_q == trg_f_q)
        glitch_q <= 4'h0;
      else if (glitch_q + 4'h1 >= 4'(atf_pkg::GLITCH_CYC))
      begin
        trg_f_q <= trg_s2_q;
        glitch_q <= 4'h0;
      end
      else
        glitch_q <= glitch_q + 4'h1;
    end
  assign edge_hit = trg_f_q != trg_s2_q && glitch_q + 4'h1 >= 4'(atf_pkg::GLITCH_CYC)
    && (trg_s2_q ^ ctl_q[atf_pkg::CTL_EDGE]);

  // Trigger qualification; the sw start is held until a converter tick samples it
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      armed_q <= 1'b0;
      sw_pend_q <= 1'b0;
    end
    else
    begin
      if (sw_start && seq_q == atf_pkg::SEQ_IDLE)
      begin
        if (ctl_q[atf_pkg::CTL_EXT_SEL])
          armed_q <= 1'b1;
        else
          sw_pend_q <= 1'b1;
      end
      if (push_q)
        armed_q <= 1'b0;
      if (seq_q != atf_pkg::SEQ_IDLE)
        sw_pend_q <= 1'b0;
    end

  logic ext_pend_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ext_pend_q <= 1'b0;
    else if (seq_q != atf_pkg::SEQ_IDLE)
      ext_pend_q <= 1'b0;
    else if (edge_hit && ctl_q[atf_pkg::CTL_EXT_SEL] &&
             (ctl_q[atf_pkg::CTL_AUTO] || armed_q))
      ext_pend_q <= 1'b1;

  // Sequencer on converter ticks
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      seq_q <= atf_pkg::SEQ_IDLE;
      dly_cnt_q <= 8'h00;
      dly_div_q <= 2'h0;
      conv_cnt_q <= 8'h00;
      conv_start <= 1'b0;
      push_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      if (cc_tick)
        unique case (seq_q)
          atf_pkg::SEQ_IDLE:
            if (sw_pend_q || ext_pend_q)
            begin
              seq_q <= atf_pkg::SEQ_DELAY;
              dly_cnt_q <= dly_q[7:0];
              dly_div_q <= 2'h0;
            end
          atf_pkg::SEQ_DELAY:
          begin
            dly_div_q <= dly_div_q + 2'h1;
            if (dly_cnt_q == 8'h00)
            begin
              seq_q <= atf_pkg::SEQ_CONV;
              conv_start <= 1'b1;
              conv_cnt_q <= 8'(atf_pkg::CONV_CYC - 1);
            end
            else if (dly_div_q == 2'(atf_pkg::DLY_DIV - 1))
              dly_cnt_q <= dly_cnt_q - 8'h01;
          end
          atf_pkg::SEQ_CONV:
          begin
            conv_start <= 1'b0;
            if (conv_cnt_q == 8'h00)
            begin
              seq_q <= atf_pkg::SEQ_IDLE;
              push_q <= 1'b1;
            end
            else
              conv_cnt_q <= conv_cnt_q - 8'h01;
          end
        endcase
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      route <= '0;
    else
      route <= gcr_q;

  // Result queue on the system clock
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
      ovf_q <= 1'b0;
      done_q <= 1'b0;
      for (int i = 0; i < atf_pkg::FIFO_DEPTH; i++)
        fifo_q[i] <= '0;
    end
    else
    begin
      if (pop)
      begin
        rp_q <= rp_q + 2'h1;
        fifo_q[rp_q].ovf <= 1'b0;
        ovf_q <= 1'b0;
        done_q <= 1'b0;
      end
      if (push_q)
      begin
        done_q <= 1'b1;
        if (cnt_q == 3'(atf_pkg::FIFO_DEPTH) && !pop)
          ovf_q <= 1'b1;
        else
        begin
          fifo_q[wp_q] <= '{ovf: 1'b0, data: conv_data_in};
          wp_q <= wp_q + 2'h1;
        end
      end
      if (push_q && !(cnt_q == 3'(atf_pkg::FIFO_DEPTH) && !pop) && !pop)
        cnt_q <= cnt_q + 3'h1;
      else if (pop && !push_q)
        cnt_q <= cnt_q - 3'h1;
    end

  // Wake follows queue state directly; irq is one stage later
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      pop_gap_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      pop_gap_q <= pop;
      wake_q <= ((cnt_q != 3'h0 || push_q) && !pop) ||
        (gcr_q.touch == atf_pkg::TOUCH_PEN && pen_s2_q);
      // Irq trails wake by one cycle, so its one-cycle gap after a read lands one cycle later
      irq_q <= cnt_q != 3'h0 && !pop_gap_q;
    end
  assign conv_wake_line = wake_q;
  assign conv_irq_line = irq_q;

  a_queue_bound: assert property (@(posedge clk) disable iff (rst)
    cnt_q <= 3'(atf_pkg::FIFO_DEPTH)) else $error("queue count too large");
  a_ovf_on_full: assert property (@(posedge clk) disable iff (rst)
    push_q && cnt_q == 3'(atf_pkg::FIFO_DEPTH) && !pop |=> ovf_q)
    else $error("overflow not flagged");
  a_done_set: assert property (@(posedge clk) disable iff (rst)
    push_q |=> done_q) else $error("done not set");
  a_irq_read_drop: assert property (@(posedge clk) disable iff (rst)
    pop |-> ##2 !conv_irq_line) else $error("irq did not drop");
  a_wake_read_drop: assert property (@(posedge clk) disable iff (rst)
    pop && gcr_q.touch != atf_pkg::TOUCH_PEN |=> !conv_wake_line)
    else $error("wake did not drop");
  a_wake_first: assert property (@(posedge clk) disable iff (rst)
    $rose(conv_irq_line) |-> conv_wake_line) else $error("irq before wake");
  a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
    seq_q == atf_pkg::SEQ_CONV && cc_tick && conv_cnt_q != 8'h00 |=> seq_q == atf_pkg::SEQ_CONV)
    else $error("conversion cut short");
  a_disarm_push: assert property (@(posedge clk) disable iff (rst)
    push_q |=> !armed_q) else $error("trigger still armed");
endmodule // atf_top

/* File: atf_pkg.sv */
package atf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_START = 8'h04;
  localparam logic [7:0] OFF_DELAY = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_GLOBAL = 8'h10;
  localparam logic [7:0] OFF_AUX = 8'h14;
  // Control register fields
  localparam int CTL_EXT_SEL = 0;
  localparam int CTL_EDGE = 1;
  localparam int CTL_AUTO = 2;
  // Result register fields
  localparam int RES_DATA_W = 13;
  localparam int RES_PEN = 13;
  localparam int RES_OVF = 14;
  localparam int RES_DONE = 15;
  localparam int RES_VALID = 16;
  // Global config field positions
  localparam int GCR_CHAN = 0;
  localparam int GCR_EXTIN = 4;
  localparam int GCR_PREF = 5;
  localparam int GCR_NREF = 7;
  localparam int GCR_TOUCH = 9;
  // Touch driver codes
  localparam logic [2:0] TOUCH_X = 3'h2;
  localparam logic [2:0] TOUCH_Y = 3'h1;
  localparam logic [2:0] TOUCH_Z = 3'h4;
  localparam logic [2:0] TOUCH_PEN = 3'h5;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0;
  localparam logic [7:0] RST_CLK_DIV = 8'h03;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int GLITCH_NS = 10;
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_US = 15;
  localparam int CONV_MHZ = 12;
  localparam int CONV_CYC = CONV_US * CONV_MHZ;
  localparam int FIFO_DEPTH = 4;
  localparam int DLY_DIV = 4;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_CONV} atf_seq_t;

  typedef struct packed {
    logic [2:0] touch;
    logic [1:0] nref;
    logic [1:0] pref;
    logic ext_in;
    logic [3:0] chan;
  } atf_route_t;

  typedef struct packed {
    logic ovf;
    logic [12:0] data;
  } atf_entry_t;
endpackage

/* File: atf_conv_model.sv */
module atf_conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Converter side of the block
  input wire logic conv_start,
  input wire atf_pkg::atf_route_t route,
  input wire logic pen_level,
  output logic [12:0] conv_data_in,
  output logic pen_detect_in
);
  logic start_q;
  logic [7:0] n_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_q <= 1'b0;
      n_q <= 8'h00;
    end
    else
    begin
      start_q <= conv_start;
      if (conv_start && !start_q)
        n_q <= n_q + 8'h01;
    end
  end

  // Sample code carries the routed channel, so a misrouted mux shows in the data
  assign conv_data_in = {1'b0, route.chan, n_q};
  assign pen_detect_in = pen_level;
endmodule // atf_conv_model

/* File: atf_top_tb.sv */
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
  end

module atf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, aux_clk_in, ext_trigger_in, pen_level, pen_detect_in;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] conv_data_in;
  logic conv_start, conv_clk_en, conv_irq_line, conv_wake_line;
  atf_pkg::atf_route_t route;
  int n_errors = 0;
  int samples_checked = 0;

  atf_top uut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_trigger_in, .aux_clk_in, .pen_detect_in, .conv_data_in, .conv_start, .conv_clk_en,
    .route, .conv_irq_line, .conv_wake_line
  );

  atf_conv_model model (
    .clk, .rst, .conv_start, .route, .pen_level, .conv_data_in, .pen_detect_in
  );

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("[FAIL] wait exp answer got timeout");
    final_report();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    if (i == 50)
      hang();
    `CHK("bresp", 2'h0, s_axi_bresp)
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    if (i == 50)
      hang();
    d = s_axi_rdata;
    `CHK("rresp", 2'h0, s_axi_rresp)
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [31:0] res(bit dn, bit ov, bit pn, logic [3:0] ch, logic [7:0] n);
    return {15'h0, 1'b1, dn, ov, pn, 1'b0, ch, n};
  endfunction

  // Drop counts are only meaningful while entries remain behind the one read
  task automatic pop(output logic [31:0] d, input bit more);
    int lo_i = 0;
    int lo_w = 0;
    fork
      rd(atf_pkg::OFF_RESULT, d);
      repeat (8)
      begin
        @(posedge clk);
        #1;
        lo_i += !conv_irq_line;
        lo_w += !conv_wake_line;
      end
    join
    if (more)
    begin
      `CHK("irq_drop", 1, lo_i)
      `CHK("wake_drop", 1, lo_w)
    end
  endtask

  task automatic wait_wake(input bit lag);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      #1;
      if (conv_wake_line === 1'b1)
        break;
    end
    if (i == 3000)
      hang();
    if (lag)
    begin
      `CHK("irq_lag", 1'b0, conv_irq_line)
      @(posedge clk);
      #1;
      `CHK("irq_rise", 1'b1, conv_irq_line)
    end
  endtask

  task automatic pulse(input logic v);
    @(posedge clk);
    ext_trigger_in <= v;
    repeat (3) @(posedge clk);
    ext_trigger_in <= ~v;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(atf_pkg::OFF_RESULT, d);
    `CHK("res_rst", 32'h0, d)
    rd(8'h1c, d);
    `CHK("unmapped", 32'h0, d)
    rd(atf_pkg::OFF_AUX, d);
    `CHK("aux_rst", {24'h0, atf_pkg::RST_CLK_DIV}, d)
    `CHK("irq_rst", 1'b0, conv_irq_line)
    `CHK("wake_rst", 1'b0, conv_wake_line)
  endtask

  task automatic t_sw();
    logic [31:0] d;
    wr(atf_pkg::OFF_START, 32'h5a5a_a5a5);
    wait_wake(1);
    pop(d, 0);
    `CHK("res_sw", res(1, 0, 0, 4'h0, 8'h01), d)
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq_empty", 1'b0, conv_irq_line)
    `CHK("wake_empty", 1'b0, conv_wake_line)
  endtask

  task automatic t_fill();
    logic [31:0] d;
    for (int k = 0; k < 5; k++)
    begin
      wr(atf_pkg::OFF_START, {28'h0, 4'(k)});
      repeat (900) @(posedge clk);
    end
    pop(d, 1);
    `CHK("res_ovf", res(1, 1, 0, 4'h0, 8'h02), d)
    for (int k = 1; k < 4; k++)
    begin
      pop(d, k < 3);
      `CHK("res_fifo", {2'b10, 5'h0, 8'(2 + k)}, {d[16:15], d[12:0]})
    end
    rd(atf_pkg::OFF_RESULT, d);
    `CHK("res_drain", 1'b0, d[16])
  endtask

  task automatic t_ext();
    logic [31:0] d;
    wr(atf_pkg::OFF_CONTROL, 32'h5);
    pulse(1);
    repeat (100) @(posedge clk);
    pulse(1);
    wait_wake(0);
    pop(d, 0);
    `CHK("res_auto", res(1, 0, 0, 4'h0, 8'h07), d)
    repeat (900) @(posedge clk);
    rd(atf_pkg::OFF_RESULT, d);
    `CHK("res_busy", 1'b0, d[16])
    wr(atf_pkg::OFF_CONTROL, 32'h0);
    ext_trigger_in <= 1'b1;
    wr(atf_pkg::OFF_CONTROL, 32'h7);
    pulse(0);
    wait_wake(0);
    pop(d, 0);
    `CHK("res_fall", res(1, 0, 0, 4'h0, 8'h08), d)
    wr(atf_pkg::OFF_CONTROL, 32'h0);
    ext_trigger_in <= 1'b0;
  endtask

  task automatic t_prime();
    logic [31:0] d;
    wr(atf_pkg::OFF_CONTROL, 32'h1);
    pulse(1);
    repeat (900) @(posedge clk);
    `CHK("unprimed", 1'b0, conv_wake_line)
    wr(atf_pkg::OFF_START, 32'h0);
    pulse(1);
    wait_wake(0);
    pop(d, 0);
    `CHK("res_prime", res(1, 0, 0, 4'h0, 8'h09), d)
    pulse(1);
    repeat (900) @(posedge clk);
    `CHK("disarmed", 1'b0, conv_wake_line)
    wr(atf_pkg::OFF_CONTROL, 32'h0);
  endtask

  task automatic t_pen();
    logic [31:0] d;
    logic [2:0] codes [3] = '{atf_pkg::TOUCH_X, atf_pkg::TOUCH_Y, atf_pkg::TOUCH_Z};
    foreach (codes[j])
    begin
      wr(atf_pkg::OFF_GLOBAL, {20'h0, codes[j], 9'h0});
      @(posedge clk);
      `CHK("touch", codes[j], route.touch)
    end
    wr(atf_pkg::OFF_GLOBAL, 32'h0000_0a05);
    @(posedge clk);
    `CHK("route", 12'ha05, route)
    pen_level <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("wake_pen", 1'b1, conv_wake_line)
    `CHK("irq_pen", 1'b0, conv_irq_line)
    wr(atf_pkg::OFF_START, 32'h0);
    repeat (900) @(posedge clk);
    pop(d, 0);
    `CHK("res_pen", res(1, 0, 1, 4'h5, 8'h0a), d)
    pen_level <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK("wake_nopen", 1'b0, conv_wake_line)
  endtask

  task automatic t_clk();
    int n;
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      n += conv_clk_en;
    end
    `CHK("tick_div3", 10, n)
    wr(atf_pkg::OFF_AUX, 32'h07);
    repeat (20) @(posedge clk);
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      n += conv_clk_en;
    end
    `CHK("tick_div7", 5, n)
    wr(atf_pkg::OFF_AUX, {24'h0, atf_pkg::RST_CLK_DIV});
  endtask

  task automatic t_rerst();
    logic [31:0] d;
    wr(atf_pkg::OFF_START, 32'h0);
    wait_wake(0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq_rerst", 1'b0, conv_irq_line)
    `CHK("wake_rerst", 1'b0, conv_wake_line)
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(atf_pkg::OFF_RESULT, d);
    `CHK("res_rerst", 32'h0, d)
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Aux source runs unrelated to clk, though the bench keeps the divider selected
  initial
  begin
    aux_clk_in = 1'b0;
    forever #37 aux_clk_in = ~aux_clk_in;
  end

  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    ext_trigger_in = 1'b0;
    pen_level = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_sw();
    t_fill();
    t_ext();
    t_prime();
    t_pen();
    t_clk();
    t_rerst();
    final_report();
  end
endmodule // atf_top_tb
